// >>> design/ldc_defines.vh
// ldc_defines.vh: register map, field positions, reset values, codes
// and timing figures of the listen duty-cycle and battery detect block.
// assumes: included by bare name from every ldc design file.
`ifndef LDC_DEFINES_VH
`define LDC_DEFINES_VH

// register offsets, 7-bit register address space
`define LDC_ADDR_W 7
`define LDC_ADDR_BATT 7'h0C
`define LDC_ADDR_CFG 7'h0D
`define LDC_ADDR_IDLE 7'h0E
`define LDC_ADDR_RXDUR 7'h0F
`define LDC_ADDR_REV 7'h10

// battery_detect_control fields
`define LDC_BATT_LIVE_BIT 4
`define LDC_BATT_EN_BIT 3
`define LDC_BATT_TRIM_MSB 2
`define LDC_BATT_TRIM_LSB 0

// listen_config fields
`define LDC_RESOL_MSB 7
`define LDC_RESOL_LSB 4
`define LDC_CRIT_BIT 3
`define LDC_EXIT_MSB 2
`define LDC_EXIT_LSB 1

// silicon_revision fields
`define LDC_REV_FULL_MSB 7
`define LDC_REV_FULL_LSB 4
`define LDC_REV_MASK_MSB 3
`define LDC_REV_MASK_LSB 0

// reset values
`define LDC_BATT_EN_RST 1'h0
`define LDC_TRIM_RST 3'h2
`define LDC_RESOL_RST 4'hA
`define LDC_CRIT_RST 1'h0
`define LDC_EXIT_RST 2'h1
`define LDC_IDLE_COEF_RST 8'hF5
`define LDC_RX_COEF_RST 8'h20

// timing unit codes
`define LDC_RESOL_FAST 4'h5
`define LDC_RESOL_MID 4'hA
`define LDC_RESOL_SLOW 4'hF

// exit action codes
`define LDC_EXIT_STAY 2'h0
`define LDC_EXIT_TO_MODE 2'h1
`define LDC_EXIT_RESUME 2'h2

// chip mode codes
`define LDC_MODE_SLEEP 3'h0
`define LDC_MODE_STANDBY 3'h1
`define LDC_MODE_SYNTH 3'h2
`define LDC_MODE_RX 3'h4

// timing: clock period and timing units, in ns
`define LDC_CLK_PERIOD_NS 10
`define LDC_T_RES_FAST_NS 64000
`define LDC_T_RES_MID_NS 4100000
`define LDC_T_RES_SLOW_NS 262000000
`define LDC_UNIT_CW 25
// default unit lengths, in clock cycles
`define LDC_UNIT_FAST_CYC 25'h0001900
`define LDC_UNIT_MID_CYC 25'h0064190
`define LDC_UNIT_SLOW_CYC 25'h18FC2C0

`endif

// >>> design/ldc_tick_gen.v
// ldc_tick_gen.v: timing unit prescaler, one tick per selected unit.
// assumes: restart pulses at each phase start so phases align to it.
`timescale 1ns/10ps
`include "ldc_defines.vh"

module ldc_tick_gen #(
  parameter CW = `LDC_UNIT_CW,
  parameter [CW-1:0] FAST_CYC = `LDC_UNIT_FAST_CYC,
  parameter [CW-1:0] MID_CYC = `LDC_UNIT_MID_CYC,
  parameter [CW-1:0] SLOW_CYC = `LDC_UNIT_SLOW_CYC
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // control
  input wire restart,
  input wire [3:0] resol,
  // unit tick
  output wire tick
);

  reg [CW-1:0] cnt_q;
  reg [CW-1:0] period;

  // unit length by resolution code
  always @*
  begin
    case (resol)
      `LDC_RESOL_FAST: period = FAST_CYC;
      `LDC_RESOL_MID: period = MID_CYC;
      `LDC_RESOL_SLOW: period = SLOW_CYC;
      default: period = MID_CYC;
    endcase
  end

  assign tick = !restart && (cnt_q >= period - {{(CW-1){1'b0}}, 1'b1});

  always @(posedge clock)
  begin
    if (reset || restart || tick)
      cnt_q <= {CW{1'b0}};
    else
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
  end

endmodule // ldc_tick_gen

// >>> design/ldc_phase_cnt.v
// ldc_phase_cnt.v: coefficient counter for one listen phase.
// assumes: tick is a one-cycle unit pulse; start reloads the count.
`timescale 1ns/10ps
`include "ldc_defines.vh"

module ldc_phase_cnt #(
  parameter W = 8
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // control
  input wire start,
  input wire tick,
  input wire [W-1:0] coef,
  // phase end pulse
  output reg done_q
);

  reg [W-1:0] cnt_q;
  reg run_q;

  always @(posedge clock)
  begin
    if (reset)
    begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= coef;
      run_q <= 1'b1;
      done_q <= 1'b0;
    end
    else if (run_q && tick)
    begin
      // phase lasts coef units
      if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
      begin
        run_q <= 1'b0;
        done_q <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        done_q <= 1'b0;
      end
    end
    else
      done_q <= 1'b0;
  end

endmodule // ldc_phase_cnt

// >>> design/ldc_top.v
// ldc_top.v: listen duty-cycle sequencer with battery detect control,
// its register file and the read-only revision register.
// assumes: a register port already decoded from the serial host link;
// comparator, signal strength, sync match and irq inputs synchronous.
//
// Behaviour
// [R1] The battery live flag reads the comparator output as it is now.
// [R2] The battery detector is off while its enable is 0; enable resets 0.
// [R3] A three-bit trim picks the battery threshold and resets to 010.
// [R4] A four-bit resolution picks 64 us, 4.1 ms or 262 ms; reset 1010.
// [R5] Acceptance needs strength over threshold, plus sync match if set.
// [R6] Exit action 00 keeps receive after acceptance and stops listening.
// [R7] Exit action 01 waits for payload or timeout, then takes mode field.
// [R8] Exit action 10 waits for payload or timeout, then idles again.
// [R9] Receive buffer contents are flushed at the next receive wakeup.
// [R10] The idle phase lasts idle coefficient units; it resets to 0xF5.
// [R11] The receive phase lasts receive coefficient units; resets 0x20.
// [R12] The revision register holds full and mask revision nibbles.
// [R13] Exit action sits at bits 2-1 resetting to 01; bit 0 reads 0.
// [R14] With listening on, idle and receive phases alternate until a packet is accepted or the host aborts.
// [R15] The host aborts by abort bit, enable clear and new mode at once.
// [R16] Mode codes: 000 sleep, 001 standby, 010 synth, 100 receive.
`timescale 1ns/10ps
`include "ldc_defines.vh"

module ldc_top #(
  parameter UNIT_FAST_CYC = `LDC_T_RES_FAST_NS / `LDC_CLK_PERIOD_NS,
  parameter UNIT_MID_CYC = `LDC_T_RES_MID_NS / `LDC_CLK_PERIOD_NS,
  parameter UNIT_SLOW_CYC = `LDC_T_RES_SLOW_NS / `LDC_CLK_PERIOD_NS,
  parameter [3:0] REV_FULL = 4'h3, // arbitrary value
  parameter [3:0] REV_MASK = 4'h7 // arbitrary value
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // register port
  input wire [`LDC_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata_q,
  // main mode register fields
  input wire duty_cycle_enable,
  input wire duty_cycle_abort,
  input wire [2:0] mode_select,
  output reg [2:0] current_mode_q,
  // receive path events
  input wire signal_strength_threshold,
  input wire sync_word_match,
  input wire payload_complete_irq,
  input wire timeout_irq,
  output reg fifo_flush_q,
  // battery detector
  input wire battery_comparator,
  output reg battery_detector_enable_q,
  output reg [2:0] battery_threshold_trim_q
);

  // sequencer states
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_RX = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_WAIT = 3'h4;
  localparam [2:0] ST_STOP = 3'h5;

  localparam CW = `LDC_UNIT_CW;

  // configuration registers
  reg [3:0] wake_cycle_resolution_q;
  reg wake_accept_criterion_q;
  reg [1:0] wake_exit_action_q;
  reg [7:0] idle_phase_coefficient_q;
  reg [7:0] receive_phase_coefficient_q;

  // sequencer
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg start_idle;
  reg start_rx;
  reg [2:0] mode_d;

  wire unit_tick;
  wire idle_done;
  wire rx_done;
  wire accept;
  wire abort_req;
  wire [7:0] batt_rd;
  wire [7:0] cfg_rd;

  // register writes
  always @(posedge clock)
  begin
    if (reset)
    begin
      battery_detector_enable_q <= `LDC_BATT_EN_RST; // [R2]
      battery_threshold_trim_q <= `LDC_TRIM_RST; // [R3]
      wake_cycle_resolution_q <= `LDC_RESOL_RST; // [R4]
      wake_accept_criterion_q <= `LDC_CRIT_RST; // [R5]
      wake_exit_action_q <= `LDC_EXIT_RST; // [R13]
      idle_phase_coefficient_q <= `LDC_IDLE_COEF_RST; // [R10]
      receive_phase_coefficient_q <= `LDC_RX_COEF_RST; // [R11]
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `LDC_ADDR_BATT:
        begin
          // live flag bit is not writable
          battery_detector_enable_q <= reg_wdata[`LDC_BATT_EN_BIT]; // [R2]
          battery_threshold_trim_q <=
            reg_wdata[`LDC_BATT_TRIM_MSB:`LDC_BATT_TRIM_LSB]; // [R3]
        end
        `LDC_ADDR_CFG:
        begin
          wake_cycle_resolution_q <=
            reg_wdata[`LDC_RESOL_MSB:`LDC_RESOL_LSB]; // [R4]
          wake_accept_criterion_q <= reg_wdata[`LDC_CRIT_BIT]; // [R5]
          wake_exit_action_q <=
            reg_wdata[`LDC_EXIT_MSB:`LDC_EXIT_LSB]; // [R13]
        end
        `LDC_ADDR_IDLE:
          idle_phase_coefficient_q <= reg_wdata; // [R10]
        `LDC_ADDR_RXDUR:
          receive_phase_coefficient_q <= reg_wdata; // [R11]
        default:
          idle_phase_coefficient_q <= idle_phase_coefficient_q;
      endcase
    end
  end

  // read images
  assign batt_rd = {3'h0, battery_comparator, // [R1]
    battery_detector_enable_q, battery_threshold_trim_q};
  assign cfg_rd = {wake_cycle_resolution_q, wake_accept_criterion_q,
    wake_exit_action_q, 1'b0}; // [R13]

  // register reads, unmapped reads return zero
  always @(posedge clock)
  begin
    if (reset)
      reg_rdata_q <= 8'h00;
    else if (reg_read)
    begin
      case (reg_addr)
        `LDC_ADDR_BATT: reg_rdata_q <= batt_rd; // [R1]
        `LDC_ADDR_CFG: reg_rdata_q <= cfg_rd;
        `LDC_ADDR_IDLE: reg_rdata_q <= idle_phase_coefficient_q;
        `LDC_ADDR_RXDUR: reg_rdata_q <= receive_phase_coefficient_q;
        `LDC_ADDR_REV: reg_rdata_q <= {REV_FULL, REV_MASK}; // [R12]
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // timing unit prescaler, realigned at each phase start
  ldc_tick_gen #(
    .CW(CW),
    .FAST_CYC(UNIT_FAST_CYC[CW-1:0]),
    .MID_CYC(UNIT_MID_CYC[CW-1:0]),
    .SLOW_CYC(UNIT_SLOW_CYC[CW-1:0])
  ) u_tick (
    .clock(clock),
    .reset(reset),
    .restart(start_idle || start_rx),
    .resol(wake_cycle_resolution_q), // [R4]
    .tick(unit_tick)
  );

  // idle phase length
  ldc_phase_cnt #(
    .W(8)
  ) u_idle_cnt (
    .clock(clock),
    .reset(reset),
    .start(start_idle),
    .tick(unit_tick),
    .coef(idle_phase_coefficient_q), // [R10]
    .done_q(idle_done)
  );

  // receive phase length, receiver startup inside it
  ldc_phase_cnt #(
    .W(8)
  ) u_rx_cnt (
    .clock(clock),
    .reset(reset),
    .start(start_rx),
    .tick(unit_tick),
    .coef(receive_phase_coefficient_q), // [R11]
    .done_q(rx_done)
  );

  // packet acceptance
  assign accept = signal_strength_threshold &&
    (!wake_accept_criterion_q || sync_word_match); // [R5]

  // abort needs abort bit with enable cleared in one access
  assign abort_req = duty_cycle_abort && !duty_cycle_enable; // [R15]

  // sequencer next state
  always @*
  begin
    state_d = state_q;
    start_idle = 1'b0;
    start_rx = 1'b0;
    if (abort_req)
      state_d = ST_OFF; // [R15]
    else
    begin
      case (state_q)
        ST_OFF:
        begin
          if (duty_cycle_enable)
          begin
            state_d = ST_IDLE;
            start_idle = 1'b1;
          end
        end
        ST_IDLE:
        begin
          if (idle_done)
          begin
            state_d = ST_RX; // [R14]
            start_rx = 1'b1;
          end
        end
        ST_RX:
        begin
          if (accept)
          begin
            case (wake_exit_action_q)
              `LDC_EXIT_TO_MODE: state_d = ST_WAIT; // [R7]
              `LDC_EXIT_RESUME: state_d = ST_WAIT; // [R8]
              default: state_d = ST_HOLD; // [R6]
            endcase
          end
          else if (rx_done)
          begin
            state_d = ST_IDLE; // [R14]
            start_idle = 1'b1;
          end
        end
        ST_HOLD:
        begin
          if (!duty_cycle_enable)
            state_d = ST_OFF; // [R6]
        end
        ST_WAIT:
        begin
          if (payload_complete_irq || timeout_irq)
          begin
            if (wake_exit_action_q == `LDC_EXIT_RESUME)
            begin
              state_d = ST_IDLE; // [R8]
              start_idle = 1'b1;
            end
            else
              state_d = ST_STOP; // [R7]
          end
        end
        ST_STOP:
        begin
          if (!duty_cycle_enable)
            state_d = ST_OFF; // [R7]
        end
        default:
          state_d = ST_OFF;
      endcase
    end
  end

  // mode shown for each state
  always @*
  begin
    case (state_d)
      ST_OFF: mode_d = mode_select; // [R16]
      ST_IDLE: mode_d = `LDC_MODE_SLEEP;
      ST_RX: mode_d = `LDC_MODE_RX;
      ST_HOLD: mode_d = `LDC_MODE_RX; // [R6]
      ST_WAIT: mode_d = `LDC_MODE_RX;
      ST_STOP: mode_d = mode_select; // [R7]
      default: mode_d = `LDC_MODE_STANDBY;
    endcase
  end

  // sequencer registers
  always @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= ST_OFF;
      current_mode_q <= `LDC_MODE_STANDBY;
      fifo_flush_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      current_mode_q <= mode_d; // [R16]
      fifo_flush_q <= start_rx; // [R9]
    end
  end

endmodule // ldc_top

// >>> testbench/ldc_top_assertions.sv
// ldc_top_assertions.sv: port level checks of the listen sequencer.
// assumes: bound into ldc_top; mode_select held to legal codes.
`timescale 1ns/10ps
module ldc_chk #(
  parameter [3:0] REV_FULL = 4'h3, // arbitrary value
  parameter [3:0] REV_MASK = 4'h7 // arbitrary value
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // register port
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata_q,
  // mode
  input wire duty_cycle_enable,
  input wire duty_cycle_abort,
  input wire [2:0] mode_select,
  input wire [2:0] current_mode_q,
  // receive events
  input wire signal_strength_threshold,
  input wire sync_word_match,
  input wire payload_complete_irq,
  input wire timeout_irq,
  input wire fifo_flush_q,
  // battery
  input wire battery_comparator,
  input wire battery_detector_enable_q,
  input wire [2:0] battery_threshold_trim_q
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  AST_LIVE: assert property (reg_read && reg_addr == 7'h0C
    |=> reg_rdata_q[4] == $past(battery_comparator))
    else $error("live flag not current");
  AST_BIT0: assert property (reg_read && reg_addr == 7'h0D
    |=> !reg_rdata_q[0]) else $error("unused bit set");
  AST_REV: assert property (reg_read && reg_addr == 7'h10
    |=> reg_rdata_q == {REV_FULL, REV_MASK}) else $error("revision");
  AST_BATT_WR: assert property (reg_write && reg_addr == 7'h0C
    |=> {battery_detector_enable_q, battery_threshold_trim_q}
    == $past(reg_wdata[3:0])) else $error("battery write");
  AST_BATT_RST: assert property ($fell(reset) |->
    !battery_detector_enable_q && battery_threshold_trim_q == 3'h2)
    else $error("battery reset");
  AST_ABORT: assert property (duty_cycle_abort && !duty_cycle_enable
    |=> current_mode_q == $past(mode_select)) else $error("abort");
  AST_MODE: assert property (current_mode_q inside
    {3'h0, 3'h1, 3'h2, 3'h4}) else $error("mode code");
  AST_FLUSH_RX: assert property (fifo_flush_q |->
    ##[0:1] current_mode_q == 3'h4) else $error("flush outside rx");
  AST_FLUSH_ONE: assert property (fifo_flush_q |=> !fifo_flush_q)
    else $error("flush too long");
endmodule // ldc_chk

bind ldc_top ldc_chk #(.REV_FULL(REV_FULL), .REV_MASK(REV_MASK)) u_chk (
  .clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata_q, .duty_cycle_enable, .duty_cycle_abort, .mode_select,
  .current_mode_q, .signal_strength_threshold, .sync_word_match,
  .payload_complete_irq, .timeout_irq, .fifo_flush_q,
  .battery_comparator, .battery_detector_enable_q,
  .battery_threshold_trim_q);

// >>> testbench/ldc_host.sv
// ldc_host.sv: host model, one register access per task call.
// assumes: called from one bench process at a time.
`timescale 1ns/10ps
module ldc_host (
  // clock
  input wire clock,
  // register port
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  initial
  begin
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // released lines show inverted values
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_addr <= ~a;
    reg_wdata <= ~d;
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_addr <= ~a;
    reg_read <= 1'b0;
  endtask
endmodule // ldc_host

// >>> testbench/ldc_top_test.sv
// ldc_top_test.sv: self-checking bench of the listen sequencer.
// assumes: ldc_host drives the register port; units of 4, 8, 16 cycles.
`timescale 1ns/10ps
module ldc_top_test;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, d;
  logic reg_write, reg_read, rd_d = 1'b0;
  logic duty_cycle_enable = 1'b0, duty_cycle_abort = 1'b0;
  logic [2:0] mode_select = 3'h1, current_mode_q;
  logic signal_strength_threshold = 1'b0, sync_word_match = 1'b0;
  logic payload_complete_irq = 1'b0, timeout_irq = 1'b0;
  logic fifo_flush_q, battery_comparator = 1'b0;
  logic battery_detector_enable_q;
  logic [2:0] battery_threshold_trim_q;
  logic [31:0] seed = 32'h9342;
  logic [7:0] exp_q [$];
  logic [7:0] rv [6] = '{8'h02, 8'hA2, 8'hF5, 8'h20, 8'h37, 8'h00};
  int bad_count = 0, tests_run = 0, n, fl = 0, f0;

  initial forever #5 clock = ~clock;

  ldc_top #(.UNIT_FAST_CYC(4), .UNIT_MID_CYC(8), .UNIT_SLOW_CYC(16)) u_dut (
    .clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata_q, .duty_cycle_enable, .duty_cycle_abort, .mode_select,
    .current_mode_q, .signal_strength_threshold, .sync_word_match,
    .payload_complete_irq, .timeout_irq, .fifo_flush_q,
    .battery_comparator, .battery_detector_enable_q,
    .battery_threshold_trim_q);
  ldc_host u_host (.clock, .reg_addr, .reg_wdata, .reg_write, .reg_read);

  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic rdx(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask

  task automatic wmode(input logic [2:0] m, input int lim);
    n = 0;
    while (current_mode_q !== m)
    begin
      @(posedge clock);
      #1;
      n++;
      if (n > lim)
      begin
        bad_count++;
        $display("[FAIL] %0t no mode %h", $time, m);
        complete_run();
      end
    end
  endtask

  task automatic hold(input logic [2:0] m, input int k);
    repeat (k)
    begin
      @(posedge clock);
      #1;
      cmp({5'h0, current_mode_q}, {5'h0, m});
    end
  endtask

  task automatic rng(input int lo);
    cmp(8'(n >= lo && n <= lo + 3), 8'h01);
  endtask

  // read results checked against oldest note
  always @(posedge clock)
  begin
    rd_d <= reg_read;
    if (rd_d && exp_q.size() > 0)
      cmp(reg_rdata_q, exp_q.pop_front());
  end
  always @(posedge clock)
    if (fifo_flush_q === 1'b1)
      fl++;

  initial
  begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++)
      rdx(7'(12 + i), rv[i]);
    repeat (3)
    begin
      d = xs();
      @(posedge clock);
      battery_comparator <= d[7];
      u_host.wr(7'h0C, d);
      rdx(7'h0C, {3'h0, d[7], d[3:0]});
    end
    for (int a = 13; a < 18; a++)
    begin
      d = xs();
      u_host.wr(7'(a), d);
      rdx(7'(a), a == 16 ? 8'h37 : a == 17 ? 8'h00 :
        a == 13 ? d & 8'hFE : d);
    end
    u_host.wr(7'h0E, 8'h02);
    u_host.wr(7'h0F, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      u_host.wr(7'h0D, {4'(5 * (i + 1)), 4'h4});
      @(posedge clock);
      duty_cycle_enable <= 1'b1;
      wmode(3'h0, 4);
      f0 = fl;
      wmode(3'h4, 80);
      rng(8 << i);
      wmode(3'h0, 80);
      rng(8 << i);
      cmp(8'(fl - f0), 8'h01);
      @(posedge clock);
      duty_cycle_abort <= 1'b1;
      duty_cycle_enable <= 1'b0;
      @(posedge clock);
      duty_cycle_abort <= 1'b0;
      wmode(3'h1, 3);
    end
    u_host.wr(7'h0F, 8'h03);
    u_host.wr(7'h0D, 8'h5C);
    @(posedge clock);
    duty_cycle_enable <= 1'b1;
    wmode(3'h4, 20);
    @(posedge clock);
    signal_strength_threshold <= 1'b1;
    wmode(3'h0, 20);
    wmode(3'h4, 20);
    @(posedge clock);
    sync_word_match <= 1'b1;
    hold(3'h4, 20);
    @(posedge clock);
    payload_complete_irq <= 1'b1;
    signal_strength_threshold <= 1'b0;
    sync_word_match <= 1'b0;
    @(posedge clock);
    payload_complete_irq <= 1'b0;
    wmode(3'h0, 2);
    f0 = fl;
    wmode(3'h4, 20);
    hold(3'h4, 1);
    cmp(8'(fl - f0), 8'h01);
    u_host.wr(7'h0D, 8'h52);
    @(posedge clock);
    signal_strength_threshold <= 1'b1;
    hold(3'h4, 20);
    @(posedge clock);
    timeout_irq <= 1'b1;
    @(posedge clock);
    timeout_irq <= 1'b0;
    wmode(3'h1, 2);
    hold(3'h1, 20);
    @(posedge clock);
    duty_cycle_enable <= 1'b0;
    signal_strength_threshold <= 1'b0;
    u_host.wr(7'h0D, 8'h50);
    @(posedge clock);
    duty_cycle_enable <= 1'b1;
    wmode(3'h4, 20);
    @(posedge clock);
    signal_strength_threshold <= 1'b1;
    @(posedge clock);
    timeout_irq <= 1'b1;
    @(posedge clock);
    timeout_irq <= 1'b0;
    hold(3'h4, 20);
    @(posedge clock);
    duty_cycle_enable <= 1'b0;
    signal_strength_threshold <= 1'b0;
    wmode(3'h1, 3);
    @(posedge clock);
    duty_cycle_enable <= 1'b1;
    mode_select <= 3'h2;
    wmode(3'h0, 4);
    @(posedge clock);
    duty_cycle_abort <= 1'b1;
    duty_cycle_enable <= 1'b0;
    @(posedge clock);
    duty_cycle_abort <= 1'b0;
    wmode(3'h2, 2);
    hold(3'h2, 20);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rdx(7'h0E, 8'hF5);
    repeat (3) @(posedge clock);
    cmp(8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule // ldc_top_test
